// *** design/smp_resp_pkg.sv ***
// shared constants and types for the smp response frame builder
package smp_resp_pkg;
  // datapath shape
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned POS_W      = 11;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned FIFO_W     = 10;
  // fixed byte values
  localparam logic [7:0] FRAME_TYPE_RESP = 8'h41;
  localparam logic [7:0] RESERVED_BYTE   = 8'h00;
  localparam logic [7:0] FILL_BYTE       = 8'h00;
  localparam logic [7:0] CRC_SLOT_BYTE   = 8'h00;
  // result codes
  localparam logic [7:0] RES_ACCEPTED     = 8'h00;
  localparam logic [7:0] RES_UNKNOWN_FUNC = 8'h01;
  localparam logic [7:0] RES_FAILED       = 8'h02;
  localparam logic [7:0] RES_BAD_LENGTH   = 8'h03;
  localparam logic [7:0] RES_NO_PHY       = 8'h10;
  localparam logic [7:0] RES_NO_INDEX     = 8'h11;
  localparam logic [7:0] RES_NO_SATA      = 8'h12;
  localparam logic [7:0] RES_BAD_PHY_OP   = 8'h13;
  localparam logic [7:0] RES_BAD_TEST     = 8'h14;
  localparam logic [7:0] RES_TEST_BUSY    = 8'h15;
  localparam logic [7:0] RES_PHY_VACANT   = 8'h16;
  // supported function codes
  localparam logic [7:0] FN_GENERAL  = 8'h00;
  localparam logic [7:0] FN_MANUF    = 8'h01;
  localparam logic [7:0] FN_DISCOVER = 8'h10;
  localparam logic [7:0] FN_ERR_LOG  = 8'h11;
  localparam logic [7:0] FN_PHY_SATA = 8'h12;
  localparam logic [7:0] FN_ROUTE_RD = 8'h13;
  localparam logic [7:0] FN_ROUTE_WR = 8'h90;
  localparam logic [7:0] FN_PHY_CTRL = 8'h91;
  localparam logic [7:0] FN_PHY_TEST = 8'h92;
  // request frame sizes in bytes, crc included
  localparam logic [10:0] LEN_SHORT = 11'h008;
  localparam logic [10:0] LEN_PHY   = 11'h010;
  localparam logic [10:0] LEN_OUT   = 11'h02c;
  // response frame layout, byte positions
  localparam logic [10:0] POS_TYPE     = 11'h000;
  localparam logic [10:0] POS_FUNC     = 11'h001;
  localparam logic [10:0] POS_RESULT   = 11'h002;
  localparam logic [10:0] POS_RSVD     = 11'h003;
  localparam logic [10:0] POS_PAY_LAST = 11'h403;
  localparam logic [10:0] POS_FRAME_MAX = 11'h408;
  localparam logic [1:0]  ALIGN_ZERO   = 2'h0;
  localparam logic [1:0]  CRC_LAST_IDX = 2'h3;
  typedef enum logic [2:0] {
    st_idle, st_eval, st_hdr, st_pay, st_drop, st_fill, st_crc
  } state_type;
endpackage : smp_resp_pkg

// *** design/smp_byte_fifo.sv ***
// small shift fifo whose head entry is the output register
`timescale 1ns/10ps
module smp_byte_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 4
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // filling side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  room_out,
  // draining side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             push;
  logic             pop;
  int               wr_idx;

  assign in_ready_out = (count != CNT_W'(DEPTH));
  assign push         = in_valid_in && in_ready_out;
  assign pop          = out_valid_out && out_ready_in;
  assign out_data_out = mem[0];

  always_comb begin
    next_count = CNT_W'(count + CNT_W'(push) - CNT_W'(pop));
    wr_idx     = int'(count) - (pop ? 1 : 0);
  end

  // room flag is taken from next_count, so it does not lag count; it keeps a spare slot for registered ready
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count         <= '0;
      out_valid_out <= 1'b0;
      room_out      <= 1'b1;
    end else begin
      count         <= next_count;
      out_valid_out <= (next_count != '0);
      room_out      <= (next_count <= CNT_W'(DEPTH - 2));
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && i == wr_idx) begin
          mem[i] <= in_data_in;
        end else if (pop && i < DEPTH - 1) begin
          mem[i] <= mem[(i + 1) % DEPTH];
        end
      end
    end
  end
endmodule : smp_byte_fifo

// *** design/smp_result_eval.sv ***
// picks the one function result code for a request
`timescale 1ns/10ps
module smp_result_eval
  import smp_resp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // request facts
  input  wire logic        load_in,
  input  wire logic [7:0]  function_in,
  input  wire logic [10:0] length_in,
  input  wire logic [7:0]  phy_id_in,
  input  wire logic [7:0]  num_phys_in,
  input  wire logic        phy_vacant_in,
  input  wire logic        table_route_in,
  input  wire logic [15:0] route_index_in,
  input  wire logic [15:0] max_route_index_in,
  input  wire logic        phy_stp_in,
  input  wire logic        sata_sel_op_in,
  input  wire logic        phy_op_known_in,
  input  wire logic        test_fn_known_in,
  input  wire logic        test_busy_in,
  input  wire logic        failed_in,
  // verdict
  output logic [7:0]       result_out
);
  logic        supported;
  logic        phy_based;
  logic        vacant_chk;
  logic [10:0] size;
  logic [7:0]  next_result;

  always_comb begin
    supported  = 1'b1;
    phy_based  = 1'b1;
    vacant_chk = 1'b1;
    size       = LEN_PHY;
    unique case (function_in)
      FN_GENERAL, FN_MANUF: begin
        phy_based = 1'b0;
        size      = LEN_SHORT;
      end
      FN_DISCOVER, FN_ERR_LOG, FN_PHY_SATA, FN_ROUTE_RD: supported = 1'b1;
      FN_ROUTE_WR, FN_PHY_CTRL: size = LEN_OUT;
      FN_PHY_TEST: begin
        size       = LEN_OUT;
        vacant_chk = 1'b0;
      end
      default: begin
        supported = 1'b0;
        phy_based = 1'b0;
      end
    endcase
  end

  // first matching check wins, so exactly one code goes out
  always_comb begin
    if (!supported) next_result = RES_UNKNOWN_FUNC;
    else if (length_in != size) next_result = RES_BAD_LENGTH;
    else if (phy_based && phy_id_in >= num_phys_in) next_result = RES_NO_PHY;
    else if (phy_based && vacant_chk && phy_vacant_in) next_result = RES_PHY_VACANT;
    else if ((function_in == FN_PHY_SATA || (function_in == FN_PHY_CTRL && sata_sel_op_in))
             && !phy_stp_in) next_result = RES_NO_SATA;
    else if ((function_in == FN_ROUTE_RD || function_in == FN_ROUTE_WR)
             && (!table_route_in || route_index_in > max_route_index_in))
      next_result = RES_NO_INDEX;
    else if (function_in == FN_PHY_CTRL && !phy_op_known_in) next_result = RES_BAD_PHY_OP;
    else if (function_in == FN_PHY_TEST && !test_fn_known_in) next_result = RES_BAD_TEST;
    else if (function_in == FN_PHY_TEST && test_busy_in) next_result = RES_TEST_BUSY;
    else if (failed_in) next_result = RES_FAILED;
    else next_result = RES_ACCEPTED;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_out <= RES_ACCEPTED;
    end else if (load_in) begin
      result_out <= next_result;
    end
  end

  chk_unknown_code: assert property (@(posedge clk_in) disable iff (rst_in)
    load_in && !supported |=> result_out == RES_UNKNOWN_FUNC)
    else $error("unsupported function not reported as unknown");

  chk_length_before_phy: assert property (@(posedge clk_in) disable iff (rst_in)
    load_in && supported && length_in != size |=> result_out == RES_BAD_LENGTH)
    else $error("length error not reported ahead of phy checks");
endmodule : smp_result_eval

// *** design/smp_response_frame_builder.sv ***
// smp response frame builder: header, payload, fill and crc slots
`timescale 1ns/10ps
// Summary of operation
// - byte 0 carries response type 41h
// - byte 1 echoes the request function code
// - accepted function reports 00h with payload
// - unsupported function reports 01h
// - supported but failed function reports 02h
// - wrong request length reports 03h
// - nonexistent phy reports 10h
// - bad route phy or index reports 11h
// - phy not in stp port reports 12h
// - unknown phy operation reports 13h, no effect
// - unknown phy test function reports 14h
// - phy already testing reports 15h
// - inaccessible phy in range reports 16h, except on the phy test function
// - payload capped at 1024, frame 1032
// - four header bytes, payload from byte 4
// - fill bytes align crc to four bytes
// - fill byte contents carry no meaning
// - four crc bytes end every frame
// - per-function request sizes detect length errors
module smp_response_frame_builder
  import smp_resp_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  // request taken from the receive side
  input  wire logic        req_valid_in,
  input  wire logic [7:0]  req_function_in,
  input  wire logic [10:0] req_length_in,
  input  wire logic        req_payload_in,
  output logic             req_ready_out,
  // facts about the addressed phy
  input  wire logic [7:0]  req_phy_id_in,
  input  wire logic [7:0]  num_phys_in,
  input  wire logic        phy_vacant_in,
  input  wire logic        phy_table_route_in,
  input  wire logic [15:0] route_index_in,
  input  wire logic [15:0] max_route_index_in,
  input  wire logic        phy_stp_in,
  input  wire logic        sata_sel_op_in,
  input  wire logic        phy_op_known_in,
  input  wire logic        test_fn_known_in,
  input  wire logic        test_busy_in,
  input  wire logic        func_failed_in,
  // go-ahead for the function to take effect
  output logic             commit_out,
  output logic [7:0]       result_out,
  // additional response bytes from the function logic
  input  wire logic        pay_valid_in,
  input  wire logic [7:0]  pay_data_in,
  input  wire logic        pay_last_in,
  output logic             pay_ready_out,
  // response byte stream toward the transport layer
  output logic             tx_valid_out,
  output logic [7:0]       tx_data_out,
  output logic             tx_crc_slot_out,
  output logic             tx_last_out,
  input  wire logic        tx_ready_in
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  state_type          state;
  state_type          next_state;
  logic [POS_W-1:0]   pos;
  logic [1:0]         crc_cnt;
  logic [7:0]         func_q;
  logic               pay_q;
  logic [7:0]         result;
  logic               take;
  logic               pay_take;
  logic               push;
  logic [FIFO_W-1:0]  push_data;
  logic               fifo_in_ready;
  logic               fifo_room;
  logic [FIFO_W-1:0]  fifo_out;

  assign take     = req_valid_in && req_ready_out;
  assign pay_take = pay_valid_in && pay_ready_out;

  // verdict is registered on the same edge that takes the request
  smp_result_eval u_eval (
    .clk_in             (ref_clk_in),
    .rst_in             (rst_in),
    .load_in            (take),
    .function_in        (req_function_in),
    .length_in          (req_length_in),
    .phy_id_in          (req_phy_id_in),
    .num_phys_in        (num_phys_in),
    .phy_vacant_in      (phy_vacant_in),
    .table_route_in     (phy_table_route_in),
    .route_index_in     (route_index_in),
    .max_route_index_in (max_route_index_in),
    .phy_stp_in         (phy_stp_in),
    .sata_sel_op_in     (sata_sel_op_in),
    .phy_op_known_in    (phy_op_known_in),
    .test_fn_known_in   (test_fn_known_in),
    .test_busy_in       (test_busy_in),
    .failed_in          (func_failed_in),
    .result_out         (result)
  );

  // output stream buffer; tx back-pressure stalls every byte source
  smp_byte_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (ref_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (push),
    .in_data_in    (push_data),
    .in_ready_out  (fifo_in_ready),
    .room_out      (fifo_room),
    .out_valid_out (tx_valid_out),
    .out_data_out  (fifo_out),
    .out_ready_in  (tx_ready_in)
  );

  assign tx_data_out     = fifo_out[BYTE_W-1:0];
  assign tx_crc_slot_out = fifo_out[BYTE_W];
  assign tx_last_out     = fifo_out[BYTE_W+1];

  // frame sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (take) next_state = st_eval;
      end
      st_eval: next_state = st_hdr;
      st_hdr: begin
        if (push && pos == POS_RSVD) begin
          if (!pay_q) next_state = st_fill;
          else if (result == RES_ACCEPTED) next_state = st_pay;
          else next_state = st_drop;
        end
      end
      st_pay: begin
        if (pay_take && pay_last_in) next_state = st_fill;
        else if (pay_take && pos == POS_PAY_LAST) next_state = st_drop;
      end
      st_drop: begin
        if (pay_take && pay_last_in) next_state = st_fill;
      end
      st_fill: begin
        if (pos[1:0] == ALIGN_ZERO) next_state = st_crc;
      end
      st_crc: begin
        if (push && crc_cnt == CRC_LAST_IDX) next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= st_idle;
    end else begin
      state <= next_state;
    end
  end

  // byte selection for each frame section
  always_comb begin
    push      = 1'b0;
    push_data = {1'b0, 1'b0, FILL_BYTE};
    unique case (state)
      st_hdr: begin
        push = fifo_in_ready;
        unique case (pos)
          POS_TYPE:   push_data = {1'b0, 1'b0, FRAME_TYPE_RESP};
          POS_FUNC:   push_data = {1'b0, 1'b0, func_q};
          POS_RESULT: push_data = {1'b0, 1'b0, result};
          default:    push_data = {1'b0, 1'b0, RESERVED_BYTE};
        endcase
      end
      st_pay: begin
        push      = pay_take;
        push_data = {1'b0, 1'b0, pay_data_in};
      end
      st_fill: begin
        // fill value is arbitrary; zero keeps the stream easy to read
        push = fifo_in_ready && (pos[1:0] != ALIGN_ZERO);
      end
      st_crc: begin
        // crc itself is inserted downstream in these marked slots
        push      = fifo_in_ready;
        push_data = {crc_cnt == CRC_LAST_IDX, 1'b1, CRC_SLOT_BYTE};
      end
      st_idle, st_eval, st_drop: push = 1'b0;
    endcase
  end

  // byte position within the frame
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pos <= POS_TYPE;
    end else if (state == st_idle) begin
      pos <= POS_TYPE;
    end else if (push) begin
      pos <= POS_W'(pos + 1'b1);
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      crc_cnt <= '0;
    end else if (state != st_crc) begin
      crc_cnt <= '0;
    end else if (push) begin
      crc_cnt <= 2'(crc_cnt + 1'b1);
    end
  end

  // request fields held for the whole frame
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      func_q <= 8'h00;
      pay_q  <= 1'b0;
    end else if (take) begin
      func_q <= req_function_in;
      pay_q  <= req_payload_in;
    end
  end

  // registered handshakes
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_ready_out <= 1'b1;
    end else begin
      req_ready_out <= (next_state == st_idle);
    end
  end

  // payload ready looks one cycle behind, so it uses the spare-slot flag
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pay_ready_out <= 1'b0;
    end else begin
      pay_ready_out <= (next_state == st_pay && fifo_room) || next_state == st_drop;
    end
  end

  // a rejected request never gets its go-ahead, so no state changes
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      commit_out <= 1'b0;
      result_out <= RES_ACCEPTED;
    end else begin
      commit_out <= (state == st_eval) && (result == RES_ACCEPTED);
      if (state == st_eval) begin
        result_out <= result;
      end
    end
  end

  chk_type_byte: assert property (
    push && state == st_hdr && pos == POS_TYPE |-> push_data[7:0] == FRAME_TYPE_RESP)
    else $error("frame type byte is not 41h");

  chk_func_echo: assert property (
    take |-> ##2 func_q == $past(req_function_in, 2))
    else $error("function byte does not echo request");

  chk_func_byte: assert property (
    push && state == st_hdr && pos == POS_FUNC |-> push_data[7:0] == func_q)
    else $error("function byte differs from held request code");

  chk_reserved_byte: assert property (
    push && state == st_hdr && pos == POS_RSVD |-> push_data[7:0] == RESERVED_BYTE)
    else $error("reserved header byte not zero");

  chk_header_start: assert property (
    take |=> state == st_eval ##1 state == st_hdr && pos == POS_TYPE)
    else $error("header does not start two cycles after request");

  chk_crc_align: assert property (
    $rose(state == st_crc) |-> pos[1:0] == ALIGN_ZERO)
    else $error("crc does not begin on a four byte boundary");

  chk_frame_max: assert property (
    state != st_idle |-> pos <= POS_FRAME_MAX)
    else $error("response frame longer than 1032 bytes");

  chk_crc_tail: assert property (
    push && state == st_crc && crc_cnt == CRC_LAST_IDX |=> state == st_idle ##1 pos == POS_TYPE)
    else $error("frame did not close after fourth crc slot");

  chk_last_is_crc: assert property (
    tx_valid_out && tx_last_out |-> tx_crc_slot_out)
    else $error("last byte is not a crc slot");

  chk_error_no_payload: assert property (
    state == st_hdr && result != RES_ACCEPTED |-> next_state != st_pay)
    else $error("payload sent with a failing result");

  chk_commit_ok: assert property (
    commit_out |-> $past(result) == RES_ACCEPTED && state == st_hdr)
    else $error("go-ahead issued for a rejected request");

  chk_no_overflow: assert property (
    push |-> fifo_in_ready)
    else $error("byte pushed into a full buffer");
endmodule : smp_response_frame_builder

// *** testbench/smp_tx_sink.sv ***
// transport side sink model: takes response bytes, may stall
`timescale 1ns/10ps
module smp_tx_sink (
  // clock, reset, pacing
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       stall_in,
  // response byte stream
  input  wire logic       valid_in,
  input  wire logic [7:0] data_in,
  input  wire logic       crc_in,
  input  wire logic       last_in,
  output logic            ready_out
);
  // sized for the largest frame
  logic [8:0]  mem [0:1031];
  logic [10:0] cnt;
  logic [10:0] len;
  int          frames;
  // half rate when stalling, so the fifo fills and refuses
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_out <= 1'b0;
    end else begin
      ready_out <= stall_in ? ~ready_out : 1'b1;
    end
  end
  // keeps every byte; fill and error payload carry no meaning here
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 11'h000;
      len <= 11'h000;
      frames <= 0;
    end else if (valid_in && ready_out) begin
      mem[cnt] <= {crc_in, data_in};
      cnt <= last_in ? 11'h000 : cnt + 11'h001;
      if (last_in) begin
        len <= cnt + 11'h001;
        frames <= frames + 1;
      end
    end
  end
endmodule : smp_tx_sink

// *** testbench/smp_response_frame_builder_bench.sv ***
// self-checking bench for the smp response frame builder
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module smp_response_frame_builder_bench
  import smp_resp_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0, with_pay = 1'b0, stall = 1'b0;
  logic        pay_valid = 1'b0, pay_last = 1'b0;
  logic [7:0]  func = 8'h00, phy_id = 8'h00, num_phys = 8'h04, pay_data = 8'h00;
  logic [10:0] len = 11'h008;
  logic [15:0] ridx = 16'h0005, rmax = 16'h0005;
  logic        vacant = 1'b0, troute = 1'b1, stp = 1'b1, sata_sel = 1'b0;
  logic        opk = 1'b1, tfk = 1'b1, busy = 1'b0, failed = 1'b0;
  logic        req_ready, commit, pay_ready, tx_valid, tx_crc, tx_last, tx_ready;
  logic [7:0]  result, tx_data;
  int          miscompares = 0, checks = 0, commits = 0;
  // code table: unknown, failed, length, phy, index, sata, op, test, busy, vacant,
  // then two overlapping faults where the earlier check must win, two other paths to 11h and 12h, then two accepted edge cases
  logic [7:0]  fn_tab [16] = '{8'h05, 8'h00, 8'h10, 8'h10, 8'h13, 8'h12, 8'h91, 8'h92,
                               8'h92, 8'h11, 8'h05, 8'h10, 8'h90, 8'h91, 8'h92, 8'h13};
  int          len_tab [16] = '{8, 8, 8, 16, 16, 16, 44, 44, 44, 16, 16, 44, 44, 44, 44, 16};
  logic [7:0]  res_tab [16] = '{8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
                                8'h15, 8'h16, 8'h01, 8'h03, 8'h11, 8'h12, 8'h00, 8'h00};

  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (commit === 1'b1) commits++;
  end

  smp_response_frame_builder smp_response_frame_builder_inst (
    .ref_clk_in(clk), .rst_in(rst), .req_valid_in(req_valid), .req_function_in(func),
    .req_length_in(len), .req_payload_in(with_pay), .req_ready_out(req_ready),
    .req_phy_id_in(phy_id), .num_phys_in(num_phys), .phy_vacant_in(vacant),
    .phy_table_route_in(troute), .route_index_in(ridx), .max_route_index_in(rmax),
    .phy_stp_in(stp), .sata_sel_op_in(sata_sel), .phy_op_known_in(opk),
    .test_fn_known_in(tfk), .test_busy_in(busy), .func_failed_in(failed),
    .commit_out(commit), .result_out(result), .pay_valid_in(pay_valid),
    .pay_data_in(pay_data), .pay_last_in(pay_last), .pay_ready_out(pay_ready),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_crc_slot_out(tx_crc),
    .tx_last_out(tx_last), .tx_ready_in(tx_ready));

  smp_tx_sink smp_tx_sink_inst (
    .clk_in(clk), .rst_in(rst), .stall_in(stall), .valid_in(tx_valid), .data_in(tx_data),
    .crc_in(tx_crc), .last_in(tx_last), .ready_out(tx_ready));

  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // one request, its payload, then the whole frame judged byte by byte
  task automatic run_frame(input logic [7:0] exp, input int np);
    int   f0, pl, tot, g;
    logic r;
    logic [8:0] e;
    f0 = smp_tx_sink_inst.frames;
    commits = 0;
    g = 0;
    with_pay = (np != 0);
    req_valid = 1'b1;
    do begin
      r = req_ready;
      @(negedge clk);
      g++;
    end while (!r && g < 9000);
    req_valid = 1'b0;
    fork
      begin
        for (int k = 0; k < np; k++) begin
          pay_valid = 1'b1;
          pay_data = 8'(k * 7 + 3);
          pay_last = (k == np - 1);
          do begin
            r = pay_ready;
            @(negedge clk);
          end while (!r);
        end
        pay_valid = 1'b0;
        pay_last = 1'b0;
      end
      while (smp_tx_sink_inst.frames == f0 && g < 9000) begin
        @(negedge clk);
        g++;
      end
    join
    `CHK("frame seen", 1'b1, smp_tx_sink_inst.frames != f0)
    // payload only on success, capped; header plus payload padded to four
    pl = (exp == 8'h00) ? ((np > 1024) ? 1024 : np) : 0;
    tot = 4 + pl + ((4 - (pl % 4)) % 4) + 4;
    `CHK("frame length", 11'(tot), smp_tx_sink_inst.len)
    for (int i = 0; i < tot; i++) begin
      e = (i == 0) ? 9'h041 : (i == 1) ? {1'b0, func} : (i == 2) ? {1'b0, exp} :
          (i >= 4 && i < 4 + pl) ? {1'b0, 8'(i * 7 - 25)} : {i >= tot - 4, 8'h00};
      `CHK("frame byte", e, smp_tx_sink_inst.mem[i])
    end
    `CHK("result", exp, result)
    `CHK("commits", (exp == 8'h00) ? 1 : 0, commits)
  endtask : run_frame

  task automatic test_reset;
    repeat (11) @(negedge clk);
    `CHK("ready in reset", 1'b1, req_ready)
    `CHK("tx valid in reset", 1'b0, tx_valid)
    `CHK("result in reset", 8'h00, result)
    @(negedge clk);
    rst = 1'b0;
    $display("test reset done");
  endtask : test_reset

  // stalled sink, odd payload needing fill, then an empty one right after
  task automatic test_accept;
    stall = 1'b1;
    run_frame(8'h00, 5);
    stall = 1'b0;
    func = 8'h10;
    len = 11'h010;
    run_frame(8'h00, 0);
    $display("test accept done");
  endtask : test_accept

  // every code at least once, with payload offered that failing codes must drop
  task automatic test_codes;
    for (int i = 0; i < 16; i++) begin
      func = fn_tab[i];
      len = 11'(len_tab[i]);
      failed = (i == 1);
      phy_id = (i == 3) ? 8'h04 : (i == 10 || i == 11) ? 8'h09 : 8'h00;
      ridx = (i == 4) ? 16'h0006 : 16'h0005;
      stp = !(i == 5 || i == 13);
      opk = (i != 6);
      tfk = (i != 7);
      busy = (i == 8);
      vacant = (i == 9 || i == 14);
      troute = (i != 12);
      sata_sel = (i == 13);
      run_frame(res_tab[i], 4);
    end
    $display("test codes done");
  endtask : test_codes

  // oversize payload is cut at the largest frame
  task automatic test_cap;
    stall = 1'b1;
    func = 8'h01;
    len = 11'h008;
    run_frame(8'h00, 1030);
    stall = 1'b0;
    $display("test cap done");
  endtask : test_cap

  initial begin
    test_reset();
    test_accept();
    test_codes();
    test_cap();
    give_verdict();
  end
  // longest test is the capped frame at half rate, well under this span
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule : smp_response_frame_builder_bench
